// ==== verilog/rtbs_pkg.sv ====
package rtbs_pkg;
   localparam int NCH        = 32;
   localparam int NBUS       = 16;
   localparam int NSW        = NCH + NBUS;
   localparam int CLK_KHZ    = 20000;
   localparam int SETTLE_US  = 10000;
   localparam int SETTLE_CYC = SETTLE_US * CLK_KHZ / 1000;
   localparam int BLINK_MS   = 250;
   localparam int BLINK_CYC  = BLINK_MS * CLK_KHZ;
   localparam int DIM_BITS   = 3;
   localparam logic [DIM_BITS-1:0] DIM_ON_SLOT = 3'h0;

   typedef enum logic [1:0] {XOP_NONE, XOP_SET, XOP_CLR_ROWS, XOP_CLR_COLS} rtbs_xop_t;
   typedef enum logic {ST_IDLE, ST_SEL} rtbs_state_t;

   typedef struct packed {
      rtbs_xop_t             op;
      logic [NCH-1:0]        rows;
      logic [NBUS-1:0]       cols;
   } rtbs_xreq_t;

   // every bit from the lowest set bit to the highest set bit
   function automatic logic [NCH-1:0] range_mask(input logic [NCH-1:0] v);
      logic [NCH-1:0] lo;
      logic [NCH-1:0] hi;
      logic           ra;
      logic           rb;
      ra = 1'b0;
      rb = 1'b0;
      lo = '0;
      hi = '0;
      for (int i = 0; i < NCH; i++) begin
         ra    = ra | v[i];
         lo[i] = ra;
      end
      for (int i = NCH - 1; i >= 0; i--) begin
         rb    = rb | v[i];
         hi[i] = rb;
      end
      return lo & hi;
   endfunction
endpackage

// ==== verilog/rtbs_xpt_matrix.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtbs_xpt_matrix
   import rtbs_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire rtbs_xreq_t        req,
   input  wire logic [NCH-1:0]    view_rows,
   output var  logic [NCH*NBUS-1:0] xpt,
   output var  logic [NCH-1:0]    row_any,
   output var  logic [NBUS-1:0]   col_any,
   output var  logic [NBUS-1:0]   view_cols
);
   logic [NBUS-1:0]     mat_reg [NCH];
   logic [NCH*NBUS-1:0] xpt_next;
   logic [NCH-1:0]      row_next;
   logic [NBUS-1:0]     col_next;
   logic [NBUS-1:0]     view_next;

   // only bits named by the request move; the rest hold
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int r = 0; r < NCH; r++) mat_reg[r] <= '0;
      end else begin
         for (int r = 0; r < NCH; r++) begin
            unique case (req.op)
               XOP_SET:      if (req.rows[r]) mat_reg[r] <= mat_reg[r] | req.cols;
               XOP_CLR_ROWS: if (req.rows[r]) mat_reg[r] <= '0;
               XOP_CLR_COLS: mat_reg[r] <= mat_reg[r] & ~req.cols;
               XOP_NONE:     mat_reg[r] <= mat_reg[r];
            endcase
         end
      end
   end

   always_comb begin
      col_next  = '0;
      view_next = '0;
      for (int r = 0; r < NCH; r++) begin
         xpt_next[r*NBUS +: NBUS] = mat_reg[r];
         row_next[r]              = |mat_reg[r];
         col_next                 = col_next | mat_reg[r];
         if (view_rows[r]) view_next = view_next | mat_reg[r];
      end
   end

   // read side is registered; costs one cycle of LED lag, harmless to the eye
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         xpt       <= '0;
         row_any   <= '0;
         col_any   <= '0;
         view_cols <= '0;
      end else begin
         xpt       <= xpt_next;
         row_any   <= row_next;
         col_any   <= col_next;
         view_cols <= view_next;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/rtbs_route_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtbs_route_ctrl
   import rtbs_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int BLINK_CYCLES  = BLINK_CYC
)
(
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire logic [NCH-1:0]      ch_route_sw,
   input  wire logic [NBUS-1:0]     bus_selector_panel_sw,
   input  wire logic                shift_sw,
   output var  logic [NCH-1:0]      channel_bus_link_led,
   output var  logic [NBUS-1:0]     bus_led,
   output var  logic [NCH*NBUS-1:0] xpt_on,
   output var  logic                sel_active
);
   localparam int SCW = $clog2(SETTLE_CYCLES + 1);
   localparam int BCW = $clog2(BLINK_CYCLES + 1);

   logic [NSW:0]         meta_reg;
   logic [NSW:0]         sync_reg;
   logic [NSW-1:0]       samp_reg;
   logic [NSW-1:0]       stab_reg;
   logic [NSW-1:0]       prev_reg;
   logic [SCW-1:0]       settle_reg;
   logic                 shift_prev_reg;
   rtbs_state_t          state_reg;
   logic [NCH-1:0]       sel_reg;
   rtbs_xreq_t           req_reg;
   logic [BCW-1:0]       blink_cnt_reg;
   logic                 blink_reg;
   logic [DIM_BITS-1:0]  pwm_reg;
   logic [NCH-1:0]       ch_led_next;
   logic [NBUS-1:0]      bus_led_next;

   logic [NCH-1:0]       row_any;
   logic [NBUS-1:0]      col_any;
   logic [NBUS-1:0]      view_cols;
   logic [NCH-1:0]       ch_now;
   logic [NBUS-1:0]      bus_now;
   logic                 ch_evt;
   logic                 bus_evt;
   logic [NCH-1:0]       ch_rng;
   logic [NBUS-1:0]      bus_rng;
   logic [NCH-1:0]       bus_rng_w;
   logic                 shift_hold;
   logic                 shift_edge;
   logic                 dim_on;
   logic                 settled;

   // panel switches are asynchronous to mclk
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= {shift_sw, bus_selector_panel_sw, ch_route_sw};
         sync_reg <= meta_reg;
      end
   end

   // a switch set is accepted once it holds still for the settle time;
   // presses landing inside that time count as simultaneous
   assign settled = (settle_reg == SCW'(SETTLE_CYCLES - 1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         samp_reg   <= '0;
         settle_reg <= '0;
      end else begin
         samp_reg <= sync_reg[NSW-1:0];
         if (sync_reg[NSW-1:0] != samp_reg) begin
            settle_reg <= '0;
         end else if (!settled) begin
            settle_reg <= settle_reg + SCW'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stab_reg       <= '0;
         prev_reg       <= '0;
         shift_prev_reg <= 1'b0;
      end else begin
         if (settled && sync_reg[NSW-1:0] == samp_reg) begin
            stab_reg <= samp_reg;
         end
         prev_reg       <= stab_reg;
         shift_prev_reg <= sync_reg[NSW];
      end
   end

   assign ch_now     = stab_reg[NCH-1:0];
   assign bus_now    = stab_reg[NSW-1:NCH];
   // a gesture starts when a group goes from no switch to some switches
   assign ch_evt     = (|ch_now) && !(|prev_reg[NCH-1:0]);
   assign bus_evt    = (|bus_now) && !(|prev_reg[NSW-1:NCH]);
   assign ch_rng     = range_mask(ch_now);
   assign bus_rng_w  = range_mask({{(NCH-NBUS){1'b0}}, bus_now});
   assign bus_rng    = bus_rng_w[NBUS-1:0];
   assign shift_hold = sync_reg[NSW];
   assign shift_edge = shift_hold && !shift_prev_reg;

   // selection state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         sel_reg   <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (ch_evt && !shift_hold) begin
                  state_reg <= ST_SEL;
                  sel_reg   <= ch_rng;
               end
            end
            ST_SEL: begin
               if (shift_edge) begin
                  state_reg <= ST_IDLE;
                  sel_reg   <= '0;
               end else if (ch_evt && !shift_hold) begin
                  if (ch_rng == sel_reg) begin
                     state_reg <= ST_IDLE;
                     sel_reg   <= '0;
                  end else begin
                     sel_reg <= ch_rng;
                  end
               end
            end
         endcase
      end
   end

   // crosspoint requests; bus-first routing is not handled, so a bus press
   // while idle without shift does nothing
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_reg <= '{op: XOP_NONE, rows: '0, cols: '0};
      end else begin
         req_reg <= '{op: XOP_NONE, rows: '0, cols: '0};
         if (ch_evt && shift_hold) begin
            req_reg <= '{op: XOP_CLR_ROWS, rows: ch_rng, cols: '0};
         end else if (bus_evt && shift_hold) begin
            req_reg <= '{op: XOP_CLR_COLS, rows: '0, cols: bus_rng};
         end else if (bus_evt && state_reg == ST_SEL && !shift_edge) begin
            req_reg <= '{op: XOP_SET, rows: sel_reg, cols: bus_rng};
         end
      end
   end

   rtbs_xpt_matrix u_matrix (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .req       (req_reg),
      .view_rows (sel_reg),
      .xpt       (xpt_on),
      .row_any   (row_any),
      .col_any   (col_any),
      .view_cols (view_cols)
   );

   // blink phase and dim pwm
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (blink_cnt_reg == BCW'(BLINK_CYCLES - 1)) begin
         blink_cnt_reg <= '0;
         blink_reg     <= !blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + BCW'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_reg <= '0;
      end else begin
         pwm_reg <= pwm_reg + DIM_BITS'(1);
      end
   end

   assign dim_on = (pwm_reg == DIM_ON_SLOT);

   // selected channels flash, routed ones glow dim; buses fed by the
   // selection are bright, other routed buses dim
   assign ch_led_next  = (sel_reg & {NCH{blink_reg}})
                       | (~sel_reg & row_any & {NCH{dim_on}});
   assign bus_led_next = view_cols | (col_any & {NBUS{dim_on}});

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         channel_bus_link_led <= '0;
         bus_led              <= '0;
         sel_active           <= 1'b0;
      end else begin
         channel_bus_link_led <= ch_led_next;
         bus_led              <= bus_led_next;
         sel_active           <= (state_reg == ST_SEL);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   chk_idle_no_sel: assert property (state_reg == ST_IDLE |-> sel_reg == '0)
      else $error("selection held while idle");

   chk_sel_flag: assert property (sel_active == $past(state_reg == ST_SEL))
      else $error("select flag does not follow state");

   chk_enter_select: assert property (
      state_reg == ST_IDLE && ch_evt && !shift_hold
      |=> state_reg == ST_SEL && sel_reg == $past(ch_rng))
      else $error("route press did not select its range");

   chk_range_mask: assert property (
      ch_evt |-> (ch_rng & ch_now) == ch_now && ch_rng[0] == ch_now[0]
      && (ch_rng & (~ch_rng + NCH'(1))) == (ch_now & (~ch_now + NCH'(1)))
      && ((ch_rng + (ch_rng & (~ch_rng + NCH'(1)))) & ch_rng) == '0)
      else $error("channel range does not cover pressed switches");

   chk_bus_range: assert property (
      bus_evt |-> (bus_rng & bus_now) == bus_now
      && ((bus_rng + (bus_rng & (~bus_rng + NBUS'(1)))) & bus_rng) == '0)
      else $error("bus range has a gap or misses a switch");

   chk_set_routes: assert property (
      state_reg == ST_SEL && bus_evt && !shift_hold && !shift_edge
      |=> req_reg.op == XOP_SET ##3 (view_cols & $past(bus_rng, 4)) == $past(bus_rng, 4))
      else $error("bus press did not make crosspoints");

   chk_range_route: assert property (
      state_reg == ST_SEL && bus_evt && !shift_hold && !shift_edge
      |=> req_reg.rows == $past(sel_reg) && req_reg.cols == $past(bus_rng))
      else $error("range request does not cover selection and bus range");

   chk_set_in_sel: assert property (
      req_reg.op == XOP_SET |-> $past(state_reg) == ST_SEL && $past(bus_evt))
      else $error("crosspoints made outside a select session");

   chk_idle_bus_off: assert property (
      state_reg == ST_IDLE && bus_evt && !shift_hold |=> req_reg.op == XOP_NONE)
      else $error("bus press while idle changed crosspoints");

   chk_set_keeps: assert property (
      req_reg.op inside {XOP_NONE, XOP_SET}
      |=> ##1 (xpt_on & $past(xpt_on)) == $past(xpt_on))
      else $error("adding a route removed another");

   chk_reselect_idle: assert property (
      state_reg == ST_SEL && !shift_edge && ch_evt && !shift_hold && ch_rng == sel_reg
      |=> state_reg == ST_IDLE)
      else $error("second route press did not return idle");

   chk_shift_escape: assert property (
      state_reg == ST_SEL && shift_edge |=> state_reg == ST_IDLE ##1 sel_active == 1'b0)
      else $error("shift did not escape select");

   chk_clear_row: assert property (
      ch_evt && shift_hold |=> req_reg.op == XOP_CLR_ROWS ##2 (row_any & $past(ch_rng, 3)) == '0)
      else $error("shift route press left crosspoints");

   chk_clear_col: assert property (
      bus_evt && shift_hold && !ch_evt
      |=> req_reg.op == XOP_CLR_COLS ##2 (col_any & $past(bus_rng, 3)) == '0)
      else $error("shift bus press left crosspoints");

   chk_shift_no_sel: assert property (
      state_reg == ST_IDLE && ch_evt && shift_hold |=> state_reg == ST_IDLE)
      else $error("route press with shift held selected a channel");

   chk_flash_sel: assert property (
      (channel_bus_link_led & $past(sel_reg)) == ($past(blink_reg) ? $past(sel_reg) : '0))
      else $error("selected channel not flashing");

   chk_ch_dim: assert property (
      $past(sel_reg) == '0
      |-> channel_bus_link_led == ($past(dim_on) ? $past(row_any) : '0))
      else $error("idle channel LEDs not at dim level");

   chk_bus_bright: assert property ((bus_led & $past(view_cols)) == $past(view_cols))
      else $error("bus fed by selection not bright");

   chk_bus_dim: assert property (
      $past(sel_reg, 2) == '0 && $past(sel_reg) == '0
      |-> bus_led == ($past(dim_on) ? $past(col_any) : '0))
      else $error("idle bus LEDs not at dim level");

   // a request reaches xpt_on two edges later, so two quiet cycles are needed
   chk_xpt_persist: assert property (
      $past(req_reg.op) == XOP_NONE && req_reg.op == XOP_NONE |=> $stable(xpt_on) [*2])
      else $error("crosspoints changed with no request");

   cov_single_route: cover property (state_reg == ST_IDLE ##1 state_reg == ST_SEL
      ##[1:1000] req_reg.op == XOP_SET);
   cov_range_route:  cover property (req_reg.op == XOP_SET && $countones(req_reg.rows) > 1
      && $countones(req_reg.cols) > 1);
   cov_shift_clear:  cover property (req_reg.op == XOP_CLR_COLS);
   cov_shift_exit:   cover property (state_reg == ST_SEL && shift_edge);
   cov_bus_pair:     cover property (bus_evt && $countones(bus_now) == 2);
endmodule
`default_nettype wire

// ==== dv/rtbs_panel_user.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtbs_panel_user
   import rtbs_pkg::*;
(
   input  wire logic            mclk,
   output var  logic [NCH-1:0]  ch_route_sw,
   output var  logic [NBUS-1:0] bus_selector_panel_sw,
   output var  logic            shift_sw
);
   // a real hand holds far longer; 16 cycles still clears the shortened settle window
   localparam int HOLD = 16;

   initial begin
      ch_route_sw           = '0;
      bus_selector_panel_sw = '0;
      shift_sw              = 1'b0;
   end

   // all switches of one gesture go down on one edge, so they count as simultaneous
   task automatic gesture(input logic [NCH-1:0] ch, input logic [NBUS-1:0] bus,
                          input logic sh);
      @(posedge mclk);
      shift_sw              <= sh;
      ch_route_sw           <= ch;
      bus_selector_panel_sw <= bus;
      repeat (HOLD) @(posedge mclk);
      shift_sw              <= 1'b0;
      ch_route_sw           <= '0;
      bus_selector_panel_sw <= '0;
      // group must read released before the next gesture
      repeat (HOLD) @(posedge mclk);
      // hand back off the edge so callers sample settled outputs
      @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== dv/bus_routing_select_controller_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module bus_routing_select_controller_test;
   import rtbs_pkg::*;
   localparam int XW = NCH * NBUS;
   logic            mclk;
   logic            rst_b;
   logic [NCH-1:0]  ch_route_sw;
   logic [NBUS-1:0] bus_selector_panel_sw;
   logic            shift_sw;
   logic [NCH-1:0]  channel_bus_link_led;
   logic [NBUS-1:0] bus_led;
   logic [XW-1:0]   xpt_on;
   logic            sel_active;
   logic [XW-1:0]   exp_x;
   int              n_mismatch;
   int              cmp_count;
   int              hi;
   int              tog;

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   rtbs_route_ctrl #(.SETTLE_CYCLES(4), .BLINK_CYCLES(8)) rtbs_route_ctrl_inst (
      .mclk                  (mclk),
      .rst_b                 (rst_b),
      .ch_route_sw           (ch_route_sw),
      .bus_selector_panel_sw (bus_selector_panel_sw),
      .shift_sw              (shift_sw),
      .channel_bus_link_led  (channel_bus_link_led),
      .bus_led               (bus_led),
      .xpt_on                (xpt_on),
      .sel_active            (sel_active)
   );

   rtbs_panel_user rtbs_panel_user_inst (
      .mclk                  (mclk),
      .ch_route_sw           (ch_route_sw),
      .bus_selector_panel_sw (bus_selector_panel_sw),
      .shift_sw              (shift_sw)
   );

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [XW-1:0] e, input logic [XW-1:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wait_sel(input logic v);
      int n;
      n = 0;
      while (sel_active !== v && n < 50) begin
         @(negedge mclk);
         n++;
      end
      check("sel_active", XW'(v), XW'(sel_active));
      if (n >= 50) close_out();
   endtask

   // sampled at the falling edge, where registered LEDs are settled
   task automatic led_stats(input logic isbus, input int idx, input int n);
      logic cur;
      logic prv;
      hi  = 0;
      tog = 0;
      prv = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         cur = isbus ? bus_led[idx] : channel_bus_link_led[idx];
         if (cur === 1'b1) hi++;
         if (i > 0 && cur !== prv) tog++;
         prv = cur;
      end
   endtask

   task automatic sc_reset();
      wait_sel(1'b0);
      check("xpt_on", '0, xpt_on);
      check("leds", '0, XW'({channel_bus_link_led, bus_led}));
   endtask

   task automatic sc_single();
      rtbs_panel_user_inst.gesture(32'h0000_0001, '0, 1'b0);
      wait_sel(1'b1);
      led_stats(1'b0, 0, 32);
      check("ch0 flashes", XW'(1), XW'(tog >= 2));
      rtbs_panel_user_inst.gesture('0, 16'h0008, 1'b0);
      exp_x[3] = 1'b1;
      check("xpt bus3", exp_x, xpt_on);
      led_stats(1'b1, 3, 16);
      check("bus3 bright", XW'(16), XW'(hi));
      rtbs_panel_user_inst.gesture('0, 16'h0020, 1'b0);
      exp_x[5] = 1'b1;
      check("xpt bus5", exp_x, xpt_on);
      rtbs_panel_user_inst.gesture(32'h0000_0001, '0, 1'b0);
      wait_sel(1'b0);
      led_stats(1'b1, 3, 16);
      check("bus3 dim", XW'(2), XW'(hi));
      led_stats(1'b0, 0, 16);
      check("ch0 dim", XW'(2), XW'(hi));
      check("xpt kept", exp_x, xpt_on);
   endtask

   task automatic sc_range();
      rtbs_panel_user_inst.gesture(32'h0000_0102, '0, 1'b0);
      wait_sel(1'b1);
      led_stats(1'b0, 4, 32);
      check("ch4 flashes", XW'(1), XW'(tog >= 2));
      rtbs_panel_user_inst.gesture('0, 16'h0009, 1'b0);
      for (int c = 1; c <= 8; c++) begin
         for (int b = 0; b <= 3; b++) exp_x[c*NBUS+b] = 1'b1;
      end
      check("xpt range", exp_x, xpt_on);
      rtbs_panel_user_inst.gesture(32'h0000_0102, '0, 1'b0);
      wait_sel(1'b0);
      led_stats(1'b0, 4, 16);
      check("ch4 dim", XW'(2), XW'(hi));
      rtbs_panel_user_inst.gesture(32'h0000_1400, '0, 1'b0);
      wait_sel(1'b1);
      rtbs_panel_user_inst.gesture('0, '0, 1'b1);
      wait_sel(1'b0);
      check("xpt after escape", exp_x, xpt_on);
   endtask

   task automatic sc_clear();
      rtbs_panel_user_inst.gesture('0, 16'h0008, 1'b1);
      for (int c = 0; c < NCH; c++) exp_x[c*NBUS+3] = 1'b0;
      check("column cleared", exp_x, xpt_on);
      rtbs_panel_user_inst.gesture(32'h0000_0002, '0, 1'b1);
      for (int b = 0; b < NBUS; b++) exp_x[NBUS+b] = 1'b0;
      check("row cleared", exp_x, xpt_on);
      wait_sel(1'b0);
   endtask

   initial begin
      rst_b      = 1'b0;
      n_mismatch = 0;
      cmp_count  = 0;
      exp_x      = '0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      sc_reset();
      sc_single();
      sc_range();
      sc_clear();
      close_out();
   end
endmodule
`default_nettype wire
